/* File: logic/ueh_pkg.sv */
// Constants, register map and encodings for the endpoint handshake controller.
// Assumes a 20 MHz system clock and word-addressed Avalon-MM register access.
package ueh_pkg;

	// Clock and handshake wait time-out (full-speed turnaround, 18 bit times)
	localparam int CLK_NS = 50;
	localparam int HS_TIMEOUT_NS = 1500;
	localparam int HS_TIMEOUT_CYC = (HS_TIMEOUT_NS / CLK_NS < 1) ? 1 : HS_TIMEOUT_NS / CLK_NS;

	// Register word addresses
	localparam logic [3:0] REG_SEL = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_IRQ = 4'h3;
	localparam logic [3:0] REG_CFG = 4'h4;

	// Select register fields
	localparam int SEL_NUM_LSB = 0;
	localparam int SEL_DIR_BIT = 4;
	localparam int SEL_BIT = 5;
	// Command register fields (write-only strobes)
	localparam int CMD_HALT_SET = 0;
	localparam int CMD_HALT_CLR = 1;
	localparam int CMD_EN_SET = 2;
	localparam int CMD_FIFO_CLR = 3;
	// Status register fields
	localparam int STAT_ACK = 0;
	localparam int STAT_NAK = 1;
	localparam int STAT_STALL = 2;
	localparam int STAT_HALT = 3;
	localparam int STAT_EN = 4;
	localparam int STAT_TXE = 5;
	// Interrupt source: receive bits from 0, transmit bits from 16
	localparam int IRQ_TX_LSB = 16;
	// Configuration fields
	localparam int CFG_NAK_EN = 0;

	// Reset values
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;
	localparam logic [3:0] RST_SEL_NUM = 4'h0;
	localparam logic RST_NAK_EN = 1'b0;

	// Latched handshake status codes {stall, nak, ack}
	localparam logic [2:0] ST_NONE = 3'h0;
	localparam logic [2:0] ST_ACK = 3'h1;
	localparam logic [2:0] ST_NAK = 3'h2;
	localparam logic [2:0] ST_STALL = 3'h4;

	typedef enum logic [1:0] {
		UEH_HS_ACK = 2'h0,
		UEH_HS_NAK = 2'h1,
		UEH_HS_STALL = 2'h2
	} ueh_hs_t;

	typedef enum logic [3:0] {
		UEH_IDLE = 4'b0001,
		UEH_OUT = 4'b0010,
		UEH_TX = 4'b0100,
		UEH_HSW = 4'b1000
	} ueh_state_t;

endpackage

/* File: logic/ueh_tmr_if.sv */
// Link between the transaction controller and its handshake wait timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface ueh_tmr_if;
	logic start;
	logic expired;
	modport ctrl (output start, input expired);
	modport tmr (input start, output expired);
endinterface

/* File: logic/ueh_hs_timer.sv */
// Handshake wait timer: counts the wait after an IN data packet.
// Assumes start is a one-cycle pulse from the controller.
`timescale 1ns/1ps
module ueh_hs_timer
	import ueh_pkg::*;
#(
	parameter int CYC = HS_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	ueh_tmr_if.tmr tif
);
	localparam int TW = $clog2(CYC + 1);

	typedef struct packed {
		logic [TW-1:0] cnt;
		logic run;
		logic expired;
	} ueh_tmr_t;

	ueh_tmr_t q, d;

	always_comb begin
		d = q;
		d.expired = 1'b0;
		if (tif.start) begin
			d.cnt = TW'(CYC - 1);
			d.run = 1'b1;
		end else if (q.run) begin
			if (q.cnt == '0) begin
				d.run = 1'b0;
				d.expired = 1'b1; // see RULE25
			end else begin
				d.cnt = q.cnt - TW'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tif.expired = q.expired;
endmodule

/* File: logic/ueh_ctrl.sv */
// Endpoint handshake controller: non-isochronous OUT error handling and IN path.
// Assumes a USB protocol engine delivering decoded token/packet events,
// external endpoint FIFOs, and an Avalon-MM master on the register port.
`timescale 1ns/1ps

// Summary of operation
// RULE1: Halted or request-error OUT gets STALL, irq
// RULE2: Halt outranks buffer enable on OUT
// RULE3: Stalled OUT clears enable and flushes FIFO
// RULE4: Software clears irq bit, then selects endpoint
// RULE5: Deselect clears latched status, rearms recording
// RULE6: Software halt needs halt-clear plus enable-set
// RULE7: Packet error or overrun: silent, enable kept
// RULE8: FIFO clear during OUT data: no handshake
// RULE9: Toggle mismatch: ACK, discard, no irq
// RULE10: Software reads no more than byte count
// RULE11: Enabled IN sends FIFO, zero-length when empty
// RULE12: Software loads FIFO, enables, then deselects
// RULE13: Host ACK on IN: irq, ACK status
// RULE14: IN with enable clear answers NAK
// RULE15: IN NAK reported only when notify enabled
// RULE16: IN NAK keeps transmit FIFO intact
// RULE17: Halted IN always STALL with irq
// RULE18: Software sets and clears halt on selection
// RULE19: Separate halts per direction, endpoint 0 shared
// RULE20: Corrupt IN token ignored, no irq
// RULE21: FIFO clear during IN data forces stuff error
// RULE22: No host handshake: time-out, data kept
// RULE23: ACKed OUT clears buffer enable
// RULE24: OUT with enable clear answers NAK
// RULE25: Handshake wait follows full-speed turnaround limit
module ueh_ctrl
	import ueh_pkg::*;
#(
	parameter int NUM_EP = 16,
	parameter int HS_CYC = HS_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tok_valid,
	input wire logic tok_in,
	input wire logic [3:0] tok_ep,
	input wire logic tok_err,
	input wire logic ctl_req_err,
	input wire logic rx_data_end,
	input wire logic rx_data_err,
	input wire logic rx_overrun,
	input wire logic rx_pid_mismatch,
	input wire logic tx_data_done,
	input wire logic host_ack,
	input wire logic tx_fifo_empty,
	output logic hs_valid,
	output logic [1:0] hs_code,
	output logic tx_start,
	output logic tx_zero_len,
	output logic tx_stuff_err,
	output logic tx_commit,
	output logic tx_rewind,
	output logic tx_flush,
	output logic rx_accept,
	output logic rx_commit,
	output logic rx_flush,
	output logic ep_irq
);
	typedef struct packed {
		ueh_state_t st;
		logic [3:0] ep;
		logic stall;
		logic en;
		logic clr_seen;
		logic [NUM_EP-1:0] halt_rx;
		logic [NUM_EP-1:0] halt_tx;
		logic [NUM_EP-1:0] en_rx;
		logic [NUM_EP-1:0] en_tx;
		logic [NUM_EP-1:0] irq_rx;
		logic [NUM_EP-1:0] irq_tx;
		logic [NUM_EP-1:0][2:0] stat_rx;
		logic [NUM_EP-1:0][2:0] stat_tx;
		logic [3:0] sel_num;
		logic sel_dir;
		logic sel_bit;
		logic nak_en;
		logic waitreq;
		logic [31:0] rdata;
		logic irq;
		logic hs_valid;
		logic [1:0] hs_code;
		logic tx_start;
		logic tx_zero;
		logic tx_stuff;
		logic tx_commit;
		logic tx_rewind;
		logic tx_flush;
		logic rx_accept;
		logic rx_commit;
		logic rx_flush;
	} ueh_ctrl_t;

	ueh_ctrl_t q, d;
	ueh_tmr_if tif ();

	// Halt lookup; endpoint 0 keeps one halt for both directions
	function automatic logic is_halted(input logic [NUM_EP-1:0] hr, input logic [NUM_EP-1:0] ht,
			input logic [3:0] e, input logic dir);
		if (e == 4'h0) begin
			is_halted = hr[0]; // see RULE19
		end else if (dir) begin
			is_halted = ht[e];
		end else begin
			is_halted = hr[e];
		end
	endfunction

	// Record a new status only while none is latched
	function automatic logic [2:0] rec(input logic [2:0] cur, input logic [2:0] code);
		rec = (cur == ST_NONE) ? code : cur; // see RULE5
	endfunction

	logic bus_req;
	logic bus_do;
	logic [31:0] rd_val;

	assign bus_req = avs_read | avs_write;
	assign bus_do = bus_req & ~q.waitreq;

	always_comb begin
		rd_val = RST_RDATA;
		if (avs_address == REG_SEL) begin
			rd_val[SEL_NUM_LSB +: 4] = q.sel_num;
			rd_val[SEL_DIR_BIT] = q.sel_dir;
			rd_val[SEL_BIT] = q.sel_bit;
		end else if (avs_address == REG_STAT) begin
			if (q.sel_dir) begin
				rd_val[STAT_STALL:STAT_ACK] = q.stat_tx[q.sel_num];
				rd_val[STAT_EN] = q.en_tx[q.sel_num];
			end else begin
				rd_val[STAT_STALL:STAT_ACK] = q.stat_rx[q.sel_num];
				rd_val[STAT_EN] = q.en_rx[q.sel_num];
			end
			rd_val[STAT_HALT] = is_halted(q.halt_rx, q.halt_tx, q.sel_num, q.sel_dir);
			rd_val[STAT_TXE] = tx_fifo_empty;
		end else if (avs_address == REG_IRQ) begin
			rd_val[NUM_EP-1:0] = q.irq_rx;
			rd_val[IRQ_TX_LSB +: NUM_EP] = q.irq_tx;
		end else if (avs_address == REG_CFG) begin
			rd_val[CFG_NAK_EN] = q.nak_en;
		end
	end

	always_comb begin
		d = q;
		d.hs_valid = 1'b0;
		d.tx_start = 1'b0;
		d.tx_stuff = 1'b0;
		d.tx_commit = 1'b0;
		d.tx_rewind = 1'b0;
		d.tx_flush = 1'b0;
		d.rx_commit = 1'b0;
		d.rx_flush = 1'b0;
		tif.start = 1'b0;

		// One wait state per access; the access acts at the edge waitrequest is seen low
		if (bus_req && q.waitreq) begin
			d.waitreq = 1'b0;
			d.rdata = rd_val;
		end else begin
			d.waitreq = 1'b1;
		end

		// Software side, applied first so hardware events below win, but a FIFO clear overrides a same-cycle data end
		if (bus_do && avs_write) begin
			if (avs_address == REG_SEL) begin
				if (q.sel_bit && !avs_writedata[SEL_BIT]) begin
					if (q.sel_dir) begin
						d.stat_tx[q.sel_num] = ST_NONE; // see RULE5
					end else begin
						d.stat_rx[q.sel_num] = ST_NONE; // see RULE5
					end
				end
				d.sel_num = avs_writedata[SEL_NUM_LSB +: 4];
				d.sel_dir = avs_writedata[SEL_DIR_BIT];
				d.sel_bit = avs_writedata[SEL_BIT];
			end else if (avs_address == REG_CMD && q.sel_bit) begin
				if (avs_writedata[CMD_HALT_SET]) begin
					if (q.sel_num == 4'h0 || !q.sel_dir) begin
						d.halt_rx[q.sel_num] = 1'b1; // see RULE18
					end else begin
						d.halt_tx[q.sel_num] = 1'b1; // see RULE19
					end
				end
				if (avs_writedata[CMD_HALT_CLR]) begin
					if (q.sel_num == 4'h0 || !q.sel_dir) begin
						d.halt_rx[q.sel_num] = 1'b0; // see RULE18
					end else begin
						d.halt_tx[q.sel_num] = 1'b0; // see RULE19
					end
				end
				if (avs_writedata[CMD_EN_SET]) begin
					if (q.sel_dir) begin
						d.en_tx[q.sel_num] = 1'b1;
					end else begin
						d.en_rx[q.sel_num] = 1'b1;
					end
				end
				if (avs_writedata[CMD_FIFO_CLR]) begin
					if (q.sel_dir) begin
						d.tx_flush = 1'b1;
						if (q.st == UEH_TX && q.ep == q.sel_num) begin
							d.tx_stuff = 1'b1; // see RULE21
							d.st = UEH_IDLE;
						end
					end else begin
						d.rx_flush = 1'b1;
						if (q.st == UEH_OUT && q.ep == q.sel_num) begin
							d.clr_seen = 1'b1; // see RULE8
						end
					end
				end
			end else if (avs_address == REG_IRQ) begin
				d.irq_rx = q.irq_rx & ~avs_writedata[NUM_EP-1:0];
				d.irq_tx = q.irq_tx & ~avs_writedata[IRQ_TX_LSB +: NUM_EP];
			end else if (avs_address == REG_CFG) begin
				d.nak_en = avs_writedata[CFG_NAK_EN];
			end
		end

		// USB transaction sequencing
		case (q.st)
			UEH_IDLE: begin
				if (tok_valid && !tok_err) begin // see RULE20
					d.ep = tok_ep;
					d.stall = is_halted(q.halt_rx, q.halt_tx, tok_ep, tok_in) | (ctl_req_err && tok_ep == 4'h0);
					d.en = tok_in ? q.en_tx[tok_ep] : q.en_rx[tok_ep];
					d.clr_seen = 1'b0;
					if (!tok_in) begin
						d.rx_accept = d.en & ~d.stall; // see RULE2
						d.st = UEH_OUT;
					end else if (d.stall) begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_STALL; // see RULE17
						d.stat_tx[tok_ep] = rec(d.stat_tx[tok_ep], ST_STALL);
						d.irq_tx[tok_ep] = 1'b1;
					end else if (!d.en) begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_NAK; // see RULE14, RULE16
						if (q.nak_en) begin
							d.stat_tx[tok_ep] = rec(d.stat_tx[tok_ep], ST_NAK); // see RULE15
							d.irq_tx[tok_ep] = 1'b1;
						end
					end else begin
						d.tx_start = 1'b1;
						d.tx_zero = tx_fifo_empty; // see RULE11
						d.st = UEH_TX;
					end
				end
			end
			UEH_OUT: begin
				if (rx_data_end) begin
					d.rx_accept = 1'b0;
					d.st = UEH_IDLE;
					if (rx_data_err || rx_overrun || d.clr_seen) begin
						d.rx_flush = 1'b1; // see RULE7
					end else if (q.stall) begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_STALL; // see RULE1
						d.stat_rx[q.ep] = rec(d.stat_rx[q.ep], ST_STALL);
						d.irq_rx[q.ep] = 1'b1;
						if (q.en_rx[q.ep]) begin
							d.en_rx[q.ep] = 1'b0; // see RULE3
							d.rx_flush = 1'b1;
						end
					end else if (rx_pid_mismatch) begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_ACK; // see RULE9
						d.rx_flush = 1'b1;
					end else if (!q.en) begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_NAK; // see RULE24
						if (q.nak_en) begin
							d.stat_rx[q.ep] = rec(d.stat_rx[q.ep], ST_NAK);
							d.irq_rx[q.ep] = 1'b1;
						end
					end else begin
						d.hs_valid = 1'b1;
						d.hs_code = UEH_HS_ACK;
						d.rx_commit = 1'b1;
						d.en_rx[q.ep] = 1'b0; // see RULE23
						d.stat_rx[q.ep] = rec(d.stat_rx[q.ep], ST_ACK);
						d.irq_rx[q.ep] = 1'b1;
					end
				end
			end
			UEH_TX: begin
				if (tx_data_done && !d.tx_stuff) begin
					tif.start = 1'b1; // see RULE25
					d.st = UEH_HSW;
				end
			end
			UEH_HSW: begin
				if (host_ack) begin
					d.tx_commit = 1'b1; // see RULE13
					d.en_tx[q.ep] = 1'b0;
					d.stat_tx[q.ep] = rec(d.stat_tx[q.ep], ST_ACK);
					d.irq_tx[q.ep] = 1'b1;
					d.st = UEH_IDLE;
				end else if (tif.expired) begin
					d.tx_rewind = 1'b1; // see RULE22
					d.st = UEH_IDLE;
				end
			end
			default: begin
				d.st = UEH_IDLE;
			end
		endcase

		d.irq = |{d.irq_rx, d.irq_tx};
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= UEH_IDLE;
			q.sel_num <= RST_SEL_NUM;
			q.nak_en <= RST_NAK_EN;
			q.waitreq <= 1'b1;
			q.rdata <= RST_RDATA;
			q.hs_code <= UEH_HS_ACK;
		end else begin
			q <= d;
		end
	end

	ueh_hs_timer #(
		.CYC(HS_CYC)
	) u_timer (
		.clk(clk),
		.arst_n(arst_n),
		.tif(tif)
	);

	assign avs_readdata = q.rdata;
	assign avs_waitrequest = q.waitreq;
	assign hs_valid = q.hs_valid;
	assign hs_code = q.hs_code;
	assign tx_start = q.tx_start;
	assign tx_zero_len = q.tx_zero;
	assign tx_stuff_err = q.tx_stuff;
	assign tx_commit = q.tx_commit;
	assign tx_rewind = q.tx_rewind;
	assign tx_flush = q.tx_flush;
	assign rx_accept = q.rx_accept;
	assign rx_commit = q.rx_commit;
	assign rx_flush = q.rx_flush;
	assign ep_irq = q.irq;
endmodule

/* File: sim/ueh_ctrl_sva.sv */
// Port assertions for the endpoint handshake controller.
// Assumes it is bound into ueh_ctrl, one clock, async active-low reset.
`timescale 1ns/1ps
module ueh_ctrl_sva
	import ueh_pkg::*;
#(
	parameter int HS_CYC = 4
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic tok_valid,
	input wire logic tok_err,
	input wire logic rx_data_end,
	input wire logic rx_data_err,
	input wire logic rx_overrun,
	input wire logic rx_pid_mismatch,
	input wire logic tx_data_done,
	input wire logic host_ack,
	input wire logic tx_fifo_empty,
	input wire logic hs_valid,
	input wire logic [1:0] hs_code,
	input wire logic tx_start,
	input wire logic tx_zero_len,
	input wire logic tx_stuff_err,
	input wire logic tx_commit,
	input wire logic tx_rewind,
	input wire logic tx_flush,
	input wire logic rx_accept,
	input wire logic rx_commit,
	input wire logic rx_flush,
	input wire logic ep_irq
);
	localparam int LIM = HS_CYC + 4;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered after one wait state");
	AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer held longer than one cycle");
	AST_STALL_IRQ: assert property (hs_valid && hs_code == UEH_HS_STALL |-> ep_irq)
		else $error("stall sent without endpoint interrupt");
	AST_ZLP: assert property (tx_start |-> tx_zero_len == $past(tx_fifo_empty))
		else $error("zero length flag does not follow fifo empty");
	AST_ACK_IRQ: assert property (host_ack |=> tx_commit && ep_irq)
		else $error("host ack not committed with interrupt");
	AST_SILENT: assert property (rx_data_end && (rx_data_err || rx_overrun) |=> !hs_valid && !rx_commit)
		else $error("handshake after bad out packet");
	AST_TOGGLE: assert property (rx_data_end && rx_pid_mismatch && !rx_data_err && !rx_overrun
		|=> hs_valid && hs_code == UEH_HS_ACK && rx_flush && !rx_commit)
		else $error("toggle mismatch not acked and discarded");
	AST_TOKERR: assert property (tok_valid && tok_err |=> (!hs_valid && !tx_start) [*3])
		else $error("corrupt token answered");
	AST_TIMEOUT: assert property (tx_data_done |-> ##[1:LIM] (tx_commit || tx_rewind))
		else $error("in data neither committed nor rewound in time");
	AST_STUFF: assert property (tx_stuff_err |-> tx_flush)
		else $error("forced stuff error without fifo flush");
	AST_COMMIT_ACC: assert property (rx_commit |-> $past(rx_accept))
		else $error("out data committed without acceptance");
	AST_STALL_NOACC: assert property (hs_valid && hs_code == UEH_HS_STALL |-> !$past(rx_accept))
		else $error("stalled out data was accepted");
endmodule
bind ueh_ctrl ueh_ctrl_sva #(.HS_CYC(HS_CYC)) ueh_ctrl_sva_inst (.clk(clk), .arst_n(arst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid),
	.tok_err(tok_err), .rx_data_end(rx_data_end), .rx_data_err(rx_data_err), .rx_overrun(rx_overrun),
	.rx_pid_mismatch(rx_pid_mismatch), .tx_data_done(tx_data_done), .host_ack(host_ack),
	.tx_fifo_empty(tx_fifo_empty), .hs_valid(hs_valid), .hs_code(hs_code), .tx_start(tx_start),
	.tx_zero_len(tx_zero_len), .tx_stuff_err(tx_stuff_err), .tx_commit(tx_commit), .tx_rewind(tx_rewind),
	.tx_flush(tx_flush), .rx_accept(rx_accept), .rx_commit(rx_commit), .rx_flush(rx_flush), .ep_irq(ep_irq));

/* File: sim/ueh_host_model.sv */
// Behavioural USB host: tokens, data phase ends and host handshakes.
// Assumes the bench calls txn from one process at a time.
`timescale 1ns/1ps
module ueh_host_model (
	input wire logic clk,
	input wire logic tx_start,
	input wire logic tx_stuff_err,
	output logic tok_valid,
	output logic tok_in,
	output logic [3:0] tok_ep,
	output logic tok_err,
	output logic rx_data_end,
	output logic rx_data_err,
	output logic rx_overrun,
	output logic rx_pid_mismatch,
	output logic tx_data_done,
	output logic host_ack
);
	logic sent = 1'h0;
	initial begin
		{tok_valid, tok_in, tok_ep, tok_err, rx_data_end, rx_data_err} = '0;
		{rx_overrun, rx_pid_mismatch, tx_data_done, host_ack} = '0;
	end
	// Device data only counts once started and not aborted
	always @(posedge clk) begin
		if (tok_valid || tx_stuff_err) sent <= 1'h0;
		else if (tx_start) sent <= 1'h1;
	end
	// Flags f: in, en, halt, err, ovr, mis, nak, ack
	task automatic txn(input logic [3:0] ep, input logic [7:0] f);
		@(posedge clk);
		tok_valid <= 1'h1;
		tok_in <= f[7];
		tok_ep <= ep;
		tok_err <= f[7] & f[4];
		@(posedge clk);
		{tok_valid, tok_err, tok_in, tok_ep} <= {2'h0, ~f[7], ~ep};
		repeat (6) @(posedge clk);
		if (!f[7]) begin
			rx_data_end <= 1'h1;
			{rx_data_err, rx_overrun, rx_pid_mismatch} <= f[4:2];
		end else tx_data_done <= sent;
		@(posedge clk);
		{rx_data_end, tx_data_done} <= 2'h0;
		{rx_data_err, rx_overrun, rx_pid_mismatch} <= ~f[4:2];
		repeat (2) @(posedge clk);
		host_ack <= f[7] & f[0] & sent;
		@(posedge clk);
		host_ack <= 1'h0;
		repeat (10) @(posedge clk);
	endtask
endmodule

/* File: sim/ueh_ctrl_bench.sv */
// Self-checking bench for the endpoint handshake controller.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module ueh_ctrl_bench
	import ueh_pkg::*;
;
	logic clk = '0, arst_n = '0, avs_read = '0, avs_write = '0, ctl_req_err = '0, tx_fifo_empty = '0;
	logic [3:0] avs_address = '0, tok_ep;
	logic [31:0] avs_writedata = '0, avs_readdata, d, s;
	logic avs_waitrequest, tok_valid, tok_in, tok_err, rx_data_end, rx_data_err, rx_overrun, rx_pid_mismatch;
	logic tx_data_done, host_ack, hs_valid, tx_start, tx_zero_len, tx_stuff_err, tx_commit, tx_rewind;
	logic tx_flush, rx_accept, rx_commit, rx_flush, ep_irq, got;
	logic [1:0] hs_code, code;
	logic [7:0] ev, f;
	int n_mismatch = 0, compares = 0, cyc = 0;
	// Rows: flags, then {hs, code, irq}, status, events
	logic [31:0] rows [13] = '{32'h40900102, 32'h00A00000, 32'h02B00200, 32'h60D00C01, 32'h50001001,
		32'h48001001, 32'h04800001, 32'hC1100130, 32'h80A00000, 32'h82B00200, 32'hA0D00C00,
		32'hC0001068, 32'h92000000};
	always #25 clk = ~clk;
	ueh_ctrl #(.HS_CYC(4)) ueh_ctrl_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tok_valid(tok_valid), .tok_in(tok_in), .tok_ep(tok_ep),
		.tok_err(tok_err), .ctl_req_err(ctl_req_err), .rx_data_end(rx_data_end), .rx_data_err(rx_data_err),
		.rx_overrun(rx_overrun), .rx_pid_mismatch(rx_pid_mismatch), .tx_data_done(tx_data_done),
		.host_ack(host_ack), .tx_fifo_empty(tx_fifo_empty), .hs_valid(hs_valid), .hs_code(hs_code),
		.tx_start(tx_start), .tx_zero_len(tx_zero_len), .tx_stuff_err(tx_stuff_err), .tx_commit(tx_commit),
		.tx_rewind(tx_rewind), .tx_flush(tx_flush), .rx_accept(rx_accept), .rx_commit(rx_commit),
		.rx_flush(rx_flush), .ep_irq(ep_irq));
	ueh_host_model ueh_host_model_inst (.clk(clk), .tx_start(tx_start), .tx_stuff_err(tx_stuff_err),
		.tok_valid(tok_valid), .tok_in(tok_in), .tok_ep(tok_ep), .tok_err(tok_err), .rx_data_end(rx_data_end),
		.rx_data_err(rx_data_err), .rx_overrun(rx_overrun), .rx_pid_mismatch(rx_pid_mismatch),
		.tx_data_done(tx_data_done), .host_ack(host_ack));
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Latch handshakes and pulses on the falling edge; cut a hang short
	always @(negedge clk) begin
		cyc <= cyc + 1;
		if (hs_valid) {got, code} <= {1'h1, hs_code};
		ev <= ev | {tx_stuff_err, tx_start & tx_zero_len, tx_start, tx_commit, tx_rewind, tx_flush, rx_commit, rx_flush};
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Register access only; FIFO data is never read here
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		{avs_address, avs_writedata, avs_read, avs_write} <= {a, v, !w, w};
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		d = avs_readdata;
		{avs_read, avs_write} <= 2'h0;
	endtask
	// Halt one endpoint direction, run one transaction, release the halt
	task automatic hx(input logic [31:0] s2, input logic [7:0] f2, input logic [2:0] e);
		bus(1, REG_SEL, s2);
		bus(1, REG_CMD, 32'h1);
		bus(1, REG_SEL, 32'h0);
		got <= 1'h0;
		ueh_host_model_inst.txn(s2[3:0], f2);
		chk({29'h0, got, code}, {29'h0, e});
		bus(1, REG_SEL, s2);
		bus(1, REG_CMD, 32'h2);
		bus(1, REG_IRQ, 32'hFFFFFFFF);
		bus(1, REG_SEL, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		chk({29'h0, avs_waitrequest, hs_valid, ep_irq}, 32'h4);
		arst_n <= 1'h1;
		bus(1, 4'hF, 32'hFFFFFFFF);
		bus(0, 4'hF, 32'h0);
		chk(d, 32'h0);
		foreach (rows[i]) begin
			f = rows[i][31:24];
			s = {26'h0, 1'h1, f[7], i[3:0] + 4'h1};
			tx_fifo_empty <= !f[0];
			bus(1, REG_CFG, {31'h0, f[1]});
			bus(1, REG_SEL, s);
			bus(1, REG_CMD, {28'h0, 1'h0, f[6], 1'h0, f[5]});
			bus(1, REG_SEL, 32'h0);
			{got, code, ev} <= '0;
			ueh_host_model_inst.txn(s[3:0], f);
			bus(1, REG_SEL, s);
			bus(0, REG_STAT, 32'h0);
			chk({8'h0, got, code, ep_irq, 7'h0, d[4:0], ev}, {8'h0, rows[i][23:0]});
			bus(1, REG_IRQ, 32'hFFFFFFFF);
			bus(1, REG_CMD, 32'h2);
			bus(1, REG_SEL, 32'h0);
			bus(1, REG_SEL, s);
			bus(0, REG_STAT, 32'h0);
			chk({27'h0, ep_irq, d[3:0]}, 32'h0);
			bus(1, REG_SEL, 32'h0);
		end
		hx(32'h30, 8'h00, 3'h6);
		hx(32'h3F, 8'h00, 3'h5);
		ctl_req_err <= 1'h1;
		got <= 1'h0;
		ueh_host_model_inst.txn(4'h0, 8'h80);
		chk({29'h0, got, code}, 32'h6);
		ctl_req_err <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			bus(1, REG_SEL, {26'h0, 1'h1, k[0], 4'hE});
			bus(1, REG_CMD, 32'h4);
			{got, ev} <= '0;
			fork
				ueh_host_model_inst.txn(4'hE, {k[0], 7'h40});
				begin
					repeat (3) @(posedge clk);
					bus(1, REG_CMD, 32'h8);
				end
			join
			chk({30'h0, got, ev[7]}, {31'h0, k[0]});
			bus(1, REG_SEL, 32'h0);
		end
		// Mid-run reset: bus idles in wait, notify enable back to its reset value
		arst_n <= 1'h0;
		@(posedge clk);
		chk({29'h0, avs_waitrequest, hs_valid, ep_irq}, 32'h4);
		arst_n <= 1'h1;
		bus(0, REG_CFG, 32'h0);
		chk(d, 32'h0);
		test_done();
	end
endmodule
